// ===== logic/ocf_fault_ctrl.sv
// Valley overcurrent pulse skipping, fault responses, retry timer and
// the open-drain fault and power-good pins of a buck regulator.
// Assumes comparator and sequencer inputs are synchronous to clock_in.
`timescale 1ns/10ps

// Overview of operation
// - On valley overcurrent hold low side for the cycle, skip next pulse.
// - Overcurrent present at pulse start still blocks that pulse.
// - Keep skipping pulses while current stays above the limit.
// - Count events at the valley; tenth one requests the fault response.
// - Three clean cycles in a row clear the event counter.
// - Eight valley limits picked by a three-bit select.
// - Limit loaded once when enable rises; new one only after enable cycle.
// - Valley protection active only with enable, in all run modes.
// - Valley events drop power-good only through the tenth-event fault latch.
// - Average overcurrent responses: shutdown, retry six then latch, retry.
// - Average overcurrent fault is reported in output-current status.
// - Register undervoltage level 50 to 400 mV in 50 mV steps.
// - Override bit selects register level over bus undervoltage limit.
// - Undervoltage responses: ignore, shutdown, retry forever.
// - Disable bit turns relative undervoltage detection off.
// - Shutdown on undervoltage flags, tristates; needs clear and enable cycle.
// - Retry tristates and runs a 1 to 8 ms timer, then checks 250 mV.
// - Below check level restart, else rerun timer and stay tristated.
// - Listed faults drop power-good, assert fault pin, latch shutdown.
// - During start-up only a high-side short asserts the fault pin.
// - Fault pin stays asserted until enable or supply is cycled.
// - With nonzero boot voltage, assert power-good after ramp to boot.
module ocf_fault_ctrl
    import ocf_pkg::*;
#(
    parameter int TICK_CYCLES = OCF_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Enable and sequencer
    input wire logic enable_in,
    input wire logic startup_active_in,
    input wire logic boot_nonzero_in,
    input wire logic boot_done_in,
    // Power stage comparators
    input wire logic valley_oc_in,
    input wire logic valley_sample_in,
    input wire logic pulse_start_in,
    input wire logic [2:0] limit_select_pin_in,
    input wire logic average_overcurrent_in,
    input wire logic uv_trip_in,
    input wire logic vout_below_check_in,
    input wire logic ovp_in,
    input wire logic boot_uvlo_in,
    input wire logic vcc_uvlo_in,
    input wire logic otp_in,
    input wire logic hss_in,
    // Bus commands
    input wire logic [1:0] oc_response_in,
    input wire logic [1:0] uv_response_in,
    input wire logic [2:0] uv_limit_bus_in,
    input wire logic [2:0] retry_time_in,
    input wire logic clear_faults_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    output logic [15:0] reg_rdata_out,
    // Power stage control
    output logic hs_block_out,
    output logic ls_hold_out,
    output logic tristate_out,
    output logic startup_req_out,
    output logic [2:0] oc_limit_out,
    output logic [2:0] uv_level_out,
    output logic oc_fault_req_out,
    // Status
    output logic iout_oc_fault_out,
    output logic uv_fault_flag_out,
    output logic latched_out,
    // Open-drain pins
    output logic catastrophic_fault_n_out,
    output logic catastrophic_fault_n_oe_out,
    output logic power_good_out,
    output logic power_good_oe_out
);

    ocf_regs_t s_reg;
    ocf_regs_t s_next;
    logic tick;
    logic tmr_clear;
    logic hard_fault;
    logic uv_event;
    logic doc_event;
    logic oc_latch;
    logic tmr_done;

    ////////////////////////////////////////////////////////////////////////
    // Retry step divider
    ocf_tick_div #(
        .CYCLES(TICK_CYCLES)
    ) u_div (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clear_in(tmr_clear),
        .tick_out(tick)
    );

    assign tmr_clear = (s_reg.st != ST_WAIT);
    assign tmr_done = tick && (s_reg.tmr == {1'b0, retry_time_in});

    ////////////////////////////////////////////////////////////////////////
    // Fault sources
    assign hard_fault = ovp_in || boot_uvlo_in || vcc_uvlo_in || otp_in
        || hss_in || s_reg.oc_req;
    assign uv_event = (s_reg.st == ST_RUN) && uv_trip_in
        && !s_reg.blank_cfg[OCF_UV_DISABLE_BIT]
        && (uv_response_in != OCF_UV_IGNORE);
    assign doc_event = (s_reg.st == ST_RUN) && average_overcurrent_in;
    assign oc_latch = (oc_response_in == OCF_OC_SHUTDOWN)
        || (oc_response_in == OCF_OC_RETRY6
            && s_reg.retry_cnt == OCF_RETRY_MAX)
        || (oc_response_in != OCF_OC_RETRY6
            && oc_response_in != OCF_OC_RETRY_ALWAYS);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_next = s_reg;
        s_next.oc_req = 1'b0;
        s_next.start_req = 1'b0;
        // Registers
        if (reg_write_in && reg_addr_in == OCF_ADDR_THR_CFG) begin
            s_next.thr_cfg = reg_wdata_in;
        end
        if (reg_write_in && reg_addr_in == OCF_ADDR_BLANK_CFG) begin
            s_next.blank_cfg = reg_wdata_in;
        end
        unique case (reg_addr_in)
            OCF_ADDR_THR_CFG: s_next.rdata = s_reg.thr_cfg;
            OCF_ADDR_BLANK_CFG: s_next.rdata = s_reg.blank_cfg;
            default: s_next.rdata = 16'h0000;
        endcase
        // Limit captured once per enable; later pin changes are ignored
        if (!enable_in) begin
            s_next.limit_loaded = 1'b0;
        end else if (!s_reg.limit_loaded) begin
            s_next.oc_limit = limit_select_pin_in;
            s_next.limit_loaded = 1'b1;
        end
        // Valley overcurrent path, only with enable
        if (!enable_in) begin
            s_next.skip_pend = 1'b0;
            s_next.hold_ls = 1'b0;
            s_next.oc_cnt = 4'h0;
            s_next.clean_cnt = 2'h0;
        end else begin
            if (pulse_start_in) begin
                s_next.skip_pend = 1'b0;
                s_next.hold_ls = 1'b0;
            end
            if (valley_oc_in) begin
                s_next.skip_pend = 1'b1;
                s_next.hold_ls = 1'b1;
            end
            if (valley_sample_in && valley_oc_in) begin
                s_next.clean_cnt = 2'h0;
                if (s_reg.oc_cnt == OCF_OC_EVENT_LIMIT - 4'h1) begin
                    s_next.oc_cnt = 4'h0;
                    s_next.oc_req = 1'b1;
                end else begin
                    s_next.oc_cnt = s_reg.oc_cnt + 4'h1;
                end
            end else if (valley_sample_in) begin
                if (s_reg.clean_cnt == OCF_CLEAN_LIMIT - 2'h1) begin
                    s_next.clean_cnt = 2'h0;
                    s_next.oc_cnt = 4'h0;
                end else begin
                    s_next.clean_cnt = s_reg.clean_cnt + 2'h1;
                end
            end
        end
        // Status flags; a new event wins over a clear in the same cycle
        if (clear_faults_in) begin
            s_next.iout_flag = 1'b0;
            s_next.uv_flag = 1'b0;
        end
        if (enable_in && average_overcurrent_in) begin
            s_next.iout_flag = 1'b1;
        end
        if (uv_event) begin
            s_next.uv_flag = 1'b1;
        end
        // Fault pin clears only when enable drops
        if (!enable_in) begin
            s_next.cat = 1'b0;
        end
        // Sequencing
        unique case (s_reg.st)
            ST_OFF: begin
                s_next.pg = 1'b0;
                if (enable_in) begin
                    s_next.st = ST_RUN;
                    s_next.start_req = 1'b1;
                    s_next.retry_cnt = 3'h0;
                end
            end
            ST_RUN: begin
                if (boot_nonzero_in && boot_done_in) begin
                    s_next.pg = 1'b1;
                end
                if (!enable_in) begin
                    s_next.st = ST_OFF;
                    s_next.pg = 1'b0;
                end else if (hard_fault) begin
                    s_next.st = ST_LATCH;
                    s_next.pg = 1'b0;
                    s_next.cat = hss_in || !startup_active_in;
                end else if (uv_event) begin
                    s_next.pg = 1'b0;
                    if (uv_response_in == OCF_UV_RETRY) begin
                        s_next.st = ST_WAIT;
                        s_next.fault_uv = 1'b1;
                        s_next.tmr = 4'h0;
                    end else begin
                        s_next.st = ST_LATCH;
                        s_next.cat = !startup_active_in;
                    end
                end else if (doc_event) begin
                    s_next.pg = 1'b0;
                    if (oc_latch) begin
                        s_next.st = ST_LATCH;
                        s_next.cat = !startup_active_in;
                    end else begin
                        s_next.st = ST_WAIT;
                        s_next.fault_uv = 1'b0;
                        s_next.tmr = 4'h0;
                        if (oc_response_in == OCF_OC_RETRY6) begin
                            s_next.retry_cnt = s_reg.retry_cnt + 3'h1;
                        end
                    end
                end
            end
            ST_WAIT: begin
                s_next.pg = 1'b0;
                if (!enable_in) begin
                    s_next.st = ST_OFF;
                end else if (hard_fault) begin
                    s_next.st = ST_LATCH;
                    s_next.cat = hss_in || !startup_active_in;
                end else if (tmr_done) begin
                    s_next.tmr = 4'h0;
                    if (!s_reg.fault_uv || vout_below_check_in) begin
                        s_next.st = ST_RUN;
                        s_next.start_req = 1'b1;
                    end
                end else if (tick) begin
                    s_next.tmr = s_reg.tmr + 4'h1;
                end
            end
            ST_LATCH: begin
                s_next.pg = 1'b0;
                // A pending undervoltage flag blocks the restart
                if (!enable_in && !s_next.uv_flag) begin
                    s_next.st = ST_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
            s_reg.st <= ST_OFF;
            s_reg.thr_cfg <= OCF_THR_CFG_RESET;
            s_reg.blank_cfg <= OCF_BLANK_CFG_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hs_block_out = (enable_in && (s_reg.skip_pend || valley_oc_in))
        || tristate_out;
    assign ls_hold_out = s_reg.hold_ls;
    assign tristate_out = (s_reg.st == ST_WAIT) || (s_reg.st == ST_LATCH);
    assign startup_req_out = s_reg.start_req;
    assign oc_limit_out = s_reg.oc_limit;
    assign uv_level_out = s_reg.thr_cfg[OCF_UV_OVERRIDE_BIT]
        ? s_reg.thr_cfg[OCF_UV_LVL_MSB:OCF_UV_LVL_LSB]
        : uv_limit_bus_in;
    assign oc_fault_req_out = s_reg.oc_req;
    assign iout_oc_fault_out = s_reg.iout_flag;
    assign uv_fault_flag_out = s_reg.uv_flag;
    assign latched_out = (s_reg.st == ST_LATCH);
    assign reg_rdata_out = s_reg.rdata;
    assign catastrophic_fault_n_out = 1'b0;
    assign catastrophic_fault_n_oe_out = s_reg.cat;
    assign power_good_out = 1'b0;
    assign power_good_oe_out = !s_reg.pg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    chk_tenth_event: assert property (
        enable_in && valley_sample_in && valley_oc_in
        && s_reg.oc_cnt == 4'h9 |=> oc_fault_req_out && s_reg.oc_cnt == 4'h0)
        else $error("tenth valley event did not request response");
    chk_clean_clear: assert property (
        enable_in && valley_sample_in && !valley_oc_in
        && s_reg.clean_cnt == 2'h2 |=> s_reg.oc_cnt == 4'h0)
        else $error("counter not cleared after three clean cycles");
    chk_skip_pulse: assert property (
        enable_in && valley_oc_in |=> hs_block_out && ls_hold_out)
        else $error("pulse not skipped after valley overcurrent");
    chk_limit_frozen: assert property (
        enable_in && s_reg.limit_loaded && $past(s_reg.limit_loaded)
        |-> $stable(oc_limit_out))
        else $error("overcurrent limit changed while enabled");
    chk_valley_off: assert property (
        !enable_in |=> !ls_hold_out && s_reg.oc_cnt == 4'h0)
        else $error("valley protection active without enable");
    chk_cat_hold: assert property (
        catastrophic_fault_n_oe_out && enable_in |=> catastrophic_fault_n_oe_out)
        else $error("fault pin released without enable cycle");
    chk_uv_level: assert property (
        s_reg.thr_cfg[15] |-> uv_level_out == s_reg.thr_cfg[10:8])
        else $error("override level not used");
    chk_uv_disable: assert property (
        s_reg.st == ST_RUN && s_reg.blank_cfg[14] && enable_in && !hard_fault
        && !doc_event |=> s_reg.st == ST_RUN)
        else $error("undervoltage acted while disabled");
    chk_hard_latch: assert property (
        s_reg.st == ST_RUN && enable_in && ovp_in
        |=> latched_out && power_good_oe_out ##1 latched_out)
        else $error("fault did not latch shutdown");
    chk_startup_cat: assert property (
        s_reg.st == ST_RUN && enable_in && otp_in && startup_active_in
        && !hss_in && !catastrophic_fault_n_oe_out
        |=> !catastrophic_fault_n_oe_out)
        else $error("fault pin asserted during start-up");
    chk_retry_hold: assert property (
        s_reg.st == ST_WAIT && enable_in && !hard_fault && tmr_done
        && s_reg.fault_uv && !vout_below_check_in |=> s_reg.st == ST_WAIT)
        else $error("restart with output above check level");

    cov_oc_request: cover property (oc_fault_req_out);
    cov_uv_retry: cover property (s_reg.st == ST_WAIT ##1 startup_req_out);
    cov_latch: cover property (latched_out && catastrophic_fault_n_oe_out);
    cov_power_good: cover property (!power_good_oe_out);

endmodule : ocf_fault_ctrl

// ===== logic/ocf_pkg.sv
// Constants, encodings and state carriers for the fault-protection logic.
// Assumes a 40 MHz core clock and 16-bit configuration registers.
package ocf_pkg;

////////////////////////////////////////////////////////////////////////////
// Clock and timing
localparam int OCF_CLK_PERIOD_NS = 25;
localparam int OCF_RETRY_STEP_MS = 1;
localparam int OCF_RETRY_STEP_NS = OCF_RETRY_STEP_MS * 1000000;
localparam int OCF_STEP_CYCLES = OCF_RETRY_STEP_NS / OCF_CLK_PERIOD_NS;

////////////////////////////////////////////////////////////////////////////
// Register map
localparam logic [7:0] OCF_ADDR_THR_CFG = 8'h5E;
localparam logic [7:0] OCF_ADDR_BLANK_CFG = 8'h60;
localparam logic [15:0] OCF_THR_CFG_RESET = 16'h0000;
localparam logic [15:0] OCF_BLANK_CFG_RESET = 16'h0000;
localparam int OCF_UV_LVL_LSB = 8;
localparam int OCF_UV_LVL_MSB = 10;
localparam int OCF_UV_OVERRIDE_BIT = 15;
localparam int OCF_UV_DISABLE_BIT = 14;

////////////////////////////////////////////////////////////////////////////
// Counts
localparam logic [3:0] OCF_OC_EVENT_LIMIT = 4'hA;
localparam logic [1:0] OCF_CLEAN_LIMIT = 2'h3;
localparam logic [2:0] OCF_RETRY_MAX = 3'h6;

////////////////////////////////////////////////////////////////////////////
// Responses
localparam logic [1:0] OCF_OC_SHUTDOWN = 2'h0;
localparam logic [1:0] OCF_OC_RETRY6 = 2'h1;
localparam logic [1:0] OCF_OC_RETRY_ALWAYS = 2'h2;
localparam logic [1:0] OCF_UV_IGNORE = 2'h0;
localparam logic [1:0] OCF_UV_SHUTDOWN = 2'h1;
localparam logic [1:0] OCF_UV_RETRY = 2'h2;

////////////////////////////////////////////////////////////////////////////
// Types
typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_RUN = 4'h2,
    ST_WAIT = 4'h4,
    ST_LATCH = 4'h8
} ocf_state_t;

typedef struct packed {
    ocf_state_t st;
    logic [15:0] thr_cfg;
    logic [15:0] blank_cfg;
    logic [15:0] rdata;
    logic [2:0] oc_limit;
    logic limit_loaded;
    logic skip_pend;
    logic hold_ls;
    logic [3:0] oc_cnt;
    logic [1:0] clean_cnt;
    logic oc_req;
    logic [2:0] retry_cnt;
    logic [3:0] tmr;
    logic fault_uv;
    logic uv_flag;
    logic iout_flag;
    logic cat;
    logic pg;
    logic start_req;
} ocf_regs_t;

typedef struct packed {
    logic [15:0] cnt;
    logic tick;
} ocf_div_t;

endpackage : ocf_pkg

// ===== logic/ocf_tick_div.sv
// Divider giving a one-cycle enable pulse per retry step.
// Assumes the clear input restarts the step so a timer starts aligned.
`timescale 1ns/10ps
module ocf_tick_div
    import ocf_pkg::*;
#(
    parameter int CYCLES = OCF_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Control
    input wire logic clear_in,
    // Step pulse
    output logic tick_out
);

    localparam logic [15:0] LAST = 16'(CYCLES - 1);

    ocf_div_t d_reg;
    ocf_div_t d_next;

    always_comb begin
        d_next = d_reg;
        d_next.tick = 1'b0;
        if (clear_in || d_reg.cnt == LAST) begin
            d_next.cnt = 16'h0000;
        end else begin
            d_next.cnt = d_reg.cnt + 16'h0001;
        end
        if (!clear_in && d_reg.cnt == LAST) begin
            d_next.tick = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            d_reg <= '0;
        end else begin
            d_reg <= d_next;
        end
    end

    assign tick_out = d_reg.tick;

endmodule : ocf_tick_div

// ===== verification/ocf_host_model.sv
// Host side model: register writer, fault clear and open-drain pull-ups.
// Assumes callers enter its tasks just after a falling clock edge.
`timescale 1ns/10ps
module ocf_host_model (
    // Clock
    input wire logic clock_in,
    // Open-drain pins and read data from the device
    input wire logic cat_drv_in,
    input wire logic cat_oe_in,
    input wire logic pg_drv_in,
    input wire logic pg_oe_in,
    input wire logic [15:0] reg_rdata_in,
    // Resolved pin levels and host requests
    output logic cat_pin_out,
    output logic pg_pin_out,
    output logic [7:0] reg_addr_out,
    output logic [15:0] reg_wdata_out,
    output logic reg_write_out,
    output logic clear_faults_out
);
    // Pull-ups to the rail win whenever the device lets go
    assign cat_pin_out = cat_oe_in ? cat_drv_in : 1'b1;
    assign pg_pin_out = pg_oe_in ? pg_drv_in : 1'b1;
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 16'h0000;
        reg_write_out = 1'b0;
        clear_faults_out = 1'b0;
    end
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_write_out = 1'b1;
        @(negedge clock_in);
        reg_write_out = 1'b0;
        // Stale data is not left on the bus
        reg_wdata_out = ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        reg_addr_out = a;
        repeat (2) @(negedge clock_in);
        d = reg_rdata_in;
    endtask : read_reg
    task automatic clear_faults();
        clear_faults_out = 1'b1;
        @(negedge clock_in);
        clear_faults_out = 1'b0;
    endtask : clear_faults
endmodule : ocf_host_model

// ===== verification/test_ocf_fault_ctrl.sv
// Self-checking bench of the fault-protection logic with a short step.
// Assumes the host model resolves pins; inputs move on falling edges.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    mismatches++; $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module test_ocf_fault_ctrl;
import ocf_pkg::*;
localparam int TICK = 8;
typedef struct packed {
    logic [7:0] a; logic [15:0] d; logic [15:0] rd; logic [2:0] lvl;
} ocf_row_t;
ocf_row_t rows [6] = '{'{8'h5E, 16'h8500, 16'h8500, 3'h5},
    '{8'h5E, 16'h8700, 16'h8700, 3'h7}, '{8'h5E, 16'h0300, 16'h0300, 3'h2},
    '{8'h60, 16'h4000, 16'h4000, 3'h2}, '{8'h33, 16'hFFFF, 16'h0000, 3'h2},
    '{8'h60, 16'h0000, 16'h0000, 3'h2}};
logic clock_in, rst_n_in, enable_in, startup_active_in, boot_nonzero_in;
logic boot_done_in, valley_oc_in, valley_sample_in, pulse_start_in;
logic average_overcurrent_in, uv_trip_in, vout_below_check_in;
logic [4:0] hard;
logic [2:0] limit_select_pin_in, retry_time_in, uv_level_out, oc_limit_out;
logic [1:0] oc_response_in, uv_response_in;
logic [7:0] reg_addr; logic [15:0] reg_wdata, reg_rdata_out, rd;
logic reg_write, clear_faults, hs_block_out, ls_hold_out, tristate_out;
logic startup_req_out, oc_fault_req_out, iout_oc_fault_out;
logic uv_fault_flag_out, latched_out, cat_n, cat_oe, pg, pg_oe, cat_pin;
logic pg_pin;
int mismatches = 0, n_compared = 0, n_req = 0, n_start = 0, r, w;
initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
end
always @(posedge clock_in) begin
    if (oc_fault_req_out === 1'b1) n_req++;
    if (startup_req_out === 1'b1) n_start++;
end
ocf_fault_ctrl #(.TICK_CYCLES(TICK)) i_dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .enable_in(enable_in),
    .startup_active_in(startup_active_in), .boot_nonzero_in(boot_nonzero_in),
    .boot_done_in(boot_done_in), .valley_oc_in(valley_oc_in),
    .valley_sample_in(valley_sample_in), .pulse_start_in(pulse_start_in),
    .limit_select_pin_in(limit_select_pin_in),
    .average_overcurrent_in(average_overcurrent_in), .uv_trip_in(uv_trip_in),
    .vout_below_check_in(vout_below_check_in), .ovp_in(hard[0]),
    .boot_uvlo_in(hard[1]), .vcc_uvlo_in(hard[2]), .otp_in(hard[3]),
    .hss_in(hard[4]), .oc_response_in(oc_response_in),
    .uv_response_in(uv_response_in), .uv_limit_bus_in(3'h2),
    .retry_time_in(retry_time_in), .clear_faults_in(clear_faults),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_write_in(reg_write), .reg_rdata_out(reg_rdata_out),
    .hs_block_out(hs_block_out), .ls_hold_out(ls_hold_out),
    .tristate_out(tristate_out), .startup_req_out(startup_req_out),
    .oc_limit_out(oc_limit_out), .uv_level_out(uv_level_out),
    .oc_fault_req_out(oc_fault_req_out),
    .iout_oc_fault_out(iout_oc_fault_out),
    .uv_fault_flag_out(uv_fault_flag_out), .latched_out(latched_out),
    .catastrophic_fault_n_out(cat_n), .catastrophic_fault_n_oe_out(cat_oe),
    .power_good_out(pg), .power_good_oe_out(pg_oe));
ocf_host_model i_host (.clock_in(clock_in), .cat_drv_in(cat_n),
    .cat_oe_in(cat_oe), .pg_drv_in(pg), .pg_oe_in(pg_oe),
    .reg_rdata_in(reg_rdata_out), .cat_pin_out(cat_pin), .pg_pin_out(pg_pin),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
    .reg_write_out(reg_write), .clear_faults_out(clear_faults));
////////////////////////////////////////////////////////////////////////////
task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
endtask : cyc
task automatic valley(input logic oc);
    valley_oc_in = oc;
    valley_sample_in = 1'b1;
    cyc(1);
    valley_sample_in = 1'b0;
    cyc(1);
endtask : valley
task automatic pulse();
    pulse_start_in = 1'b1;
    cyc(1);
    pulse_start_in = 1'b0;
endtask : pulse
task automatic done(input string nm);
    $display("test %s done", nm);
endtask : done
task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask : close_out
// Budget far above the few hundred cycles the tests need
initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    close_out();
end
////////////////////////////////////////////////////////////////////////////
initial begin
    {rst_n_in, enable_in, startup_active_in, boot_done_in} = 4'h0;
    {valley_oc_in, valley_sample_in, pulse_start_in, uv_trip_in} = 4'h0;
    {average_overcurrent_in, vout_below_check_in, hard} = 7'h00;
    boot_nonzero_in = 1'b1;
    limit_select_pin_in = 3'h5;
    retry_time_in = 3'h1;
    {oc_response_in, uv_response_in} = 4'h0;
    repeat (10) @(posedge clock_in);
    @(negedge clock_in);
    rst_n_in = 1'b1;
    `CHK("pg_reset", 1'b0, pg_pin)
    `CHK("cat_reset", 1'b1, cat_pin)
    i_host.read_reg(8'h5E, rd);
    `CHK("thr_reset", 16'h0000, rd)
    i_host.read_reg(8'h60, rd);
    `CHK("blank_reset", 16'h0000, rd)
    done("reset");
    foreach (rows[i]) begin
        i_host.write_reg(rows[i].a, rows[i].d);
        i_host.read_reg(rows[i].a, rd);
        `CHK("rdata", rows[i].rd, rd)
        `CHK("uv_level", rows[i].lvl, uv_level_out)
    end
    done("registers");
    enable_in = 1'b1;
    cyc(3);
    `CHK("limit", 3'h5, oc_limit_out)
    `CHK("pg_ramp", 1'b0, pg_pin)
    limit_select_pin_in = 3'h2;
    boot_done_in = 1'b1;
    cyc(3);
    `CHK("limit_kept", 3'h5, oc_limit_out)
    `CHK("pg_boot", 1'b1, pg_pin)
    valley_oc_in = 1'b1;
    #1 `CHK("hs_block", 1'b1, hs_block_out)
    cyc(1);
    `CHK("ls_hold", 1'b1, ls_hold_out)
    pulse();
    `CHK("hs_still", 1'b1, hs_block_out)
    valley_oc_in = 1'b0;
    #1 `CHK("skip_pend", 1'b1, hs_block_out)
    pulse();
    `CHK("hs_free", 1'b0, hs_block_out)
    done("pulse skip");
    r = n_req;
    repeat (9) valley(1'b1);
    repeat (3) valley(1'b0);
    repeat (9) valley(1'b1);
    `CHK("no_req", 0, n_req - r)
    `CHK("pg_kept", 1'b1, pg_pin)
    valley(1'b1);
    valley_oc_in = 1'b0;
    cyc(1);
    `CHK("req", 1, n_req - r)
    `CHK("oc_latch", 1'b1, latched_out)
    `CHK("oc_pg", 1'b0, pg_pin)
    cyc(5);
    `CHK("cat_held", 1'b0, cat_pin)
    enable_in = 1'b0;
    cyc(2);
    `CHK("cat_rel", 1'b1, cat_pin)
    valley_oc_in = 1'b1;
    #1 `CHK("hs_dis", 1'b0, hs_block_out)
    valley_oc_in = 1'b0;
    done("valley count");
    for (int s = 0; s < 2; s++) begin
        for (int i = 0; i < 5; i++) begin
            startup_active_in = s[0];
            enable_in = 1'b1;
            cyc(2);
            hard = 5'h01 << i;
            cyc(2);
            `CHK("hf_latch", 1'b1, latched_out)
            `CHK("hf_pg", 1'b0, pg_pin)
            `CHK("hf_cat", (s == 0 || i == 4) ? 1'b0 : 1'b1, cat_pin)
            hard = 5'h00;
            enable_in = 1'b0;
            cyc(2);
        end
    end
    startup_active_in = 1'b0;
    done("hard faults");
    enable_in = 1'b1;
    uv_response_in = OCF_UV_RETRY;
    vout_below_check_in = 1'b1;
    cyc(2);
    uv_trip_in = 1'b1;
    r = n_start;
    cyc(2);
    uv_trip_in = 1'b0;
    `CHK("uv_tri", 1'b1, tristate_out)
    `CHK("uv_flag", 1'b1, uv_fault_flag_out)
    for (w = 2; w < 100 && n_start == r; w++) cyc(1);
    `CHK("retry_time", 1'b1, w >= 2 * TICK - 1 && w <= 2 * TICK + 3)
    i_host.clear_faults();
    vout_below_check_in = 1'b0;
    uv_trip_in = 1'b1;
    cyc(2);
    uv_trip_in = 1'b0;
    r = n_start;
    cyc(40);
    `CHK("no_restart", 0, n_start - r)
    `CHK("still_tri", 1'b1, tristate_out)
    vout_below_check_in = 1'b1;
    cyc(2 * TICK + 2);
    `CHK("restart", 1, n_start - r)
    i_host.clear_faults();
    done("uv retry");
    uv_response_in = OCF_UV_SHUTDOWN;
    uv_trip_in = 1'b1;
    cyc(2);
    uv_trip_in = 1'b0;
    `CHK("uvs_latch", 1'b1, latched_out)
    enable_in = 1'b0;
    cyc(3);
    `CHK("uvs_held", 1'b1, latched_out)
    i_host.clear_faults();
    cyc(2);
    `CHK("uvs_free", 1'b0, latched_out)
    for (int k = 0; k < 2; k++) begin
        uv_response_in = k[0] ? OCF_UV_SHUTDOWN : OCF_UV_IGNORE;
        i_host.write_reg(8'h60, k[0] ? 16'h4000 : 16'h0000);
        enable_in = 1'b1;
        uv_trip_in = 1'b1;
        cyc(3);
        uv_trip_in = 1'b0;
        `CHK("uv_off", 1'b0, uv_fault_flag_out)
        `CHK("uv_run", 1'b0, tristate_out)
    end
    enable_in = 1'b0;
    done("uv shutdown");
    for (int k = 0; k < 2; k++) begin
        oc_response_in = k[0] ? OCF_OC_RETRY_ALWAYS : OCF_OC_SHUTDOWN;
        enable_in = 1'b1;
        cyc(2);
        average_overcurrent_in = 1'b1;
        cyc(2);
        average_overcurrent_in = 1'b0;
        `CHK("iout_flag", 1'b1, iout_oc_fault_out)
        `CHK("avg_latch", ~k[0], latched_out)
        `CHK("avg_tri", 1'b1, tristate_out)
        i_host.clear_faults();
        enable_in = 1'b0;
        cyc(2);
    end
    oc_response_in = OCF_OC_RETRY6;
    enable_in = 1'b1;
    cyc(2);
    r = n_start;
    average_overcurrent_in = 1'b1;
    for (w = 0; w < 400 && latched_out !== 1'b1; w++) cyc(1);
    `CHK("retry6", 6, n_start - r)
    `CHK("retry6_latch", 1'b1, latched_out)
    done("average oc");
    close_out();
end
endmodule : test_ocf_fault_ctrl
